// >>> adc_timing_pkg.sv
// constants, types and helpers shared by the conversion timing control
package adc_timing_pkg;

  localparam int          RES_W          = 10;      // result width
  localparam int          BC_STEPS       = 40;      // basic clock steps per conversion
  localparam int          STEPS_PER_BIT  = 4;       // basic clock steps per result bit
  localparam int          CAL_TICKS      = 3328;    // calibration length in basic clocks
  localparam int          LOAD_CYCLES    = 2;       // cpu clocks around result loading
  localparam int          CLK_PERIOD_NS  = 50;      // mclk period

  localparam logic [1:0]  SEL_00         = 2'h0;
  localparam logic [1:0]  SEL_01         = 2'h1;
  localparam logic [1:0]  SEL_10         = 2'h2;
  localparam logic [1:0]  SEL_11         = 2'h3;

  localparam logic [3:0]  DIV_00         = 4'h4;    // cpu clock / 4
  localparam logic [3:0]  DIV_01         = 4'h2;    // cpu clock / 2
  localparam logic [4:0]  DIV_10         = 5'h10;   // cpu clock / 16
  localparam logic [3:0]  DIV_11         = 4'h8;    // cpu clock / 8

  localparam logic [6:0]  SMP_00         = 7'h08;   // 8 basic clocks
  localparam logic [6:0]  SMP_01         = 7'h10;   // 16 basic clocks
  localparam logic [6:0]  SMP_10         = 7'h20;   // 32 basic clocks
  localparam logic [6:0]  SMP_11         = 7'h40;   // 64 basic clocks

  localparam logic [5:0]  LAST_STEP      = 6'h27;   // BC_STEPS - 1
  localparam logic [1:0]  DECIDE_PHASE   = 2'h3;    // last step of each bit
  localparam logic [11:0] CAL_LAST       = 12'hcff; // CAL_TICKS - 1
  localparam logic [9:0]  RESULT_ZERO    = 10'h000;
  localparam logic [9:0]  RESULT_FULL    = 10'h3ff;
  localparam logic [9:0]  TRIAL_MSB      = 10'h200;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10,
    ST_LOAD    = 2'b11
  } conv_state_type;

  // basic clock period in cpu clocks, minus one
  function automatic logic [3:0] bc_div_last(input logic [1:0] sel);
    logic [4:0] d;
    d = 5'h0;
    unique case (sel)
      SEL_00: d = {1'b0, DIV_00};
      SEL_01: d = {1'b0, DIV_01};
      SEL_10: d = DIV_10;
      SEL_11: d = {1'b0, DIV_11};
    endcase
    return 4'(d - 5'h1);
  endfunction

  // sample window length in basic clocks
  function automatic logic [6:0] sample_ticks(input logic [1:0] sel);
    logic [6:0] n;
    n = 7'h0;
    unique case (sel)
      SEL_00: n = SMP_00;
      SEL_01: n = SMP_01;
      SEL_10: n = SMP_10;
      SEL_11: n = SMP_11;
    endcase
    return n;
  endfunction

endpackage

// >>> bc_tick_if.sv
// basic clock tick link between sequencer and divider
interface bc_tick_if;
  logic [1:0] div_sel;   // divider select code
  logic       restart;   // realign divider phase
  logic       tick;      // one-cycle basic clock strobe

  modport divider   (input div_sel, input restart, output tick);
  modport sequencer (output div_sel, output restart, input tick);
endinterface

// >>> bc_divider.sv
// basic clock strobe generator dividing the cpu clock
module bc_divider
  import adc_timing_pkg::*;
(
  input  wire logic  mclk,     // cpu clock
  input  wire logic  sys_rst,  // sync reset, active high
  bc_tick_if.divider bc        // select, restart and tick
);

  logic [3:0] phase;

  // restart zeroes the phase so the first tick lands a whole period later
  always_ff @(posedge mclk) begin
    if (sys_rst || bc.restart) begin
      phase   <= 4'h0;
      bc.tick <= 1'b0;
    end else if (phase == bc_div_last(bc.div_sel)) begin
      phase   <= 4'h0;
      bc.tick <= 1'b1;
    end else begin
      phase   <= phase + 4'h1;
      bc.tick <= 1'b0;
    end
  end

endmodule

// >>> adc_conversion_timing_ctrl.sv
// conversion sequencer: sample window, successive approximation, calibration
//
// Overview of operation
// - The divider select code makes the basic clock cpu/4, cpu/2, cpu/16 or cpu/8 for codes 00 to 11.
// - The sample select code opens the sample window for 8, 16, 32 or 64 basic clocks for codes 00 to 11.
// - Every conversion lasts exactly the sample time plus 40 basic clocks plus 2 cpu clocks.
// - After reset a calibration of 3328 basic clocks runs before full accuracy is reached.
// - Conversions asked for during calibration still run and their time lengthens the calibration.
// - An input below ground gives all zeros and one above the reference gives all ones.
// - The input is taken only inside the sample window and later changes leave the result alone.
module adc_conversion_timing_ctrl
  import adc_timing_pkg::*;
(
  input  wire logic             mclk,                       // cpu clock, 20 MHz
  input  wire logic             sys_rst,                    // sync reset, active high
  input  wire logic             start_conversion,           // request pulse, same clock
  input  wire logic [1:0]       basic_clock_divider_select, // basic clock divider code
  input  wire logic [1:0]       sample_time_select,         // sample window code
  input  wire logic             comp_above,                 // pin: held input at or above trial
  input  wire logic             over_ref,                   // pin: input above reference
  input  wire logic             under_gnd,                  // pin: input below ground
  output logic                  sample_hold,                // high while tracking input
  output logic [RES_W-1:0]      dac_trial,                  // trial code to the dac
  output logic [RES_W-1:0]      result,                     // last conversion result
  output logic                  result_valid,               // pulse on result write
  output logic                  busy,                       // conversion in progress
  output logic                  calibrating                 // reset calibration running
);

  conv_state_type   state;
  bc_tick_if        bc ();
  logic [1:0]       comp_meta;
  logic [1:0]       comp_sync;   // [0] comparator, [1] unused slot kept zero
  logic             over_meta;
  logic             over_sync;
  logic             under_meta;
  logic             under_sync;
  logic [6:0]       smp_left;
  logic [5:0]       step;
  logic [11:0]      cal_count;
  logic             sat_high;
  logic             sat_low;
  logic             take_start;

  assign take_start = (state == ST_IDLE) && start_conversion;
  // realign basic clock so every conversion has the same length
  assign bc.restart = take_start;

  bc_divider u_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .bc      (bc)
  );

  // pins cross into mclk through two flops before any use
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      comp_meta  <= 2'h0;
      comp_sync  <= 2'h0;
      over_meta  <= 1'b0;
      over_sync  <= 1'b0;
      under_meta <= 1'b0;
      under_sync <= 1'b0;
    end else begin
      comp_meta  <= {1'b0, comp_above};
      comp_sync  <= comp_meta;
      over_meta  <= over_ref;
      over_sync  <= over_meta;
      under_meta <= under_gnd;
      under_sync <= under_meta;
    end
  end

  // divider code follows the input while idle, so a code given with the start applies to that conversion
  always_ff @(posedge mclk) begin
    if (sys_rst)
      bc.div_sel <= SEL_00;
    else if (state == ST_IDLE)
      bc.div_sel <= basic_clock_divider_select;
  end

  // main sequence; load step supplies one trailing cpu clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state    <= ST_IDLE;
      smp_left <= 7'h0;
      step     <= 6'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start_conversion) begin
            state    <= ST_SAMPLE;
            smp_left <= sample_ticks(sample_time_select);
          end
        end
        ST_SAMPLE: begin
          if (bc.tick) begin
            if (smp_left == 7'h1) begin
              state <= ST_CONVERT;
              step  <= 6'h0;
            end
            smp_left <= smp_left - 7'h1;
          end
        end
        ST_CONVERT: begin
          if (bc.tick) begin
            if (step == LAST_STEP)
              state <= ST_LOAD;
            step <= step + 6'h1;
          end
        end
        ST_LOAD: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // track only inside the window; hold thereafter
  always_ff @(posedge mclk) begin
    if (sys_rst)
      sample_hold <= 1'b0;
    else if (take_start)
      sample_hold <= 1'b1;
    else if (state == ST_SAMPLE && bc.tick && smp_left == 7'h1)
      sample_hold <= 1'b0;
  end

  // range flags frozen when the window closes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sat_high <= 1'b0;
      sat_low  <= 1'b0;
    end else if (state == ST_SAMPLE) begin
      sat_high <= over_sync;
      sat_low  <= under_sync;
    end
  end

  // successive approximation, one bit per four basic clocks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dac_trial <= RESULT_ZERO;
    end else if (state == ST_SAMPLE) begin
      dac_trial <= TRIAL_MSB;
    end else if (state == ST_CONVERT && bc.tick && step[1:0] == DECIDE_PHASE) begin
      // keep the bit on a high comparator, then try the next lower bit
      dac_trial <= (comp_sync[0] ? dac_trial : (dac_trial & ~(TRIAL_MSB >> step[5:2])))
                   | ((TRIAL_MSB >> step[5:2]) >> 1);
    end
  end

  // single write per conversion, saturating out-of-range inputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result       <= RESULT_ZERO;
      result_valid <= 1'b0;
      busy         <= 1'b0;
    end else begin
      result_valid <= (state == ST_LOAD);
      if (state == ST_LOAD) begin
        if (sat_low)
          result <= RESULT_ZERO;
        else if (sat_high)
          result <= RESULT_FULL;
        else
          result <= dac_trial;
      end
      if (take_start)
        busy <= 1'b1;
      else if (state == ST_LOAD)
        busy <= 1'b0;
    end
  end

  // calibration counts idle basic clocks only, so conversions stretch it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_count   <= 12'h0;
      calibrating <= 1'b1;
    end else if (calibrating && state == ST_IDLE && !start_conversion && bc.tick) begin
      cal_count <= cal_count + 12'h1;
      if (cal_count == CAL_LAST)
        calibrating <= 1'b0;
    end
  end

endmodule

// >>> adc_ctrl_checker.sv
// assertion checker for the conversion timing control
module adc_ctrl_checker (
  input wire logic       mclk,                       // cpu clock
  input wire logic       sys_rst,                    // sync reset
  input wire logic       start_conversion,           // request
  input wire logic [1:0] basic_clock_divider_select, // divider code
  input wire logic [1:0] sample_time_select,         // sample code
  input wire logic       over_ref,                   // above reference
  input wire logic       under_gnd,                  // below ground
  input wire logic       sample_hold,                // window open
  input wire logic [9:0] dac_trial,                  // trial code
  input wire logic [9:0] result,                     // result
  input wire logic       result_valid,               // write pulse
  input wire logic       busy,                       // converting
  input wire logic       calibrating                 // calibration
);
  timeunit 1ns;
  timeprecision 1ns;
  int   span;
  int   d_len;
  int   n_len;
  logic lo_seen;
  logic hi_seen;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // lengths latched at the accepted start, since the select inputs may move later
  always_ff @(posedge mclk) begin
    if (sys_rst || (start_conversion && !busy)) begin
      span <= 0;
      d_len <= basic_clock_divider_select == 2'h0 ? 4 : basic_clock_divider_select == 2'h1 ? 2 :
               basic_clock_divider_select == 2'h2 ? 16 : 8;
      n_len <= 8 << sample_time_select;
      lo_seen <= 1'b0;
      hi_seen <= 1'b0;
    end else begin
      span <= span + 1;
      lo_seen <= lo_seen | (sample_hold & under_gnd);
      hi_seen <= hi_seen | (sample_hold & over_ref);
    end
  end
  a_conv_length: assert property ($fell(busy) && !$past(sys_rst) |-> span == d_len * (n_len + 40) + 2)
    else $error("conversion length wrong");
  a_window_length: assert property ($fell(sample_hold) && !$past(sys_rst) |-> span == d_len * n_len + 1)
    else $error("sample window length wrong");
  a_start_opens: assert property (start_conversion && !busy |=> busy ##1 (sample_hold && dac_trial == 10'h200))
    else $error("accepted start did not open window");
  a_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("write pulse longer than one cycle");
  a_result_held: assert property (!result_valid && !$past(sys_rst) |-> $stable(result))
    else $error("result moved without write pulse");
  a_valid_ends_busy: assert property ($rose(result_valid) |-> $fell(busy))
    else $error("write pulse not at end of busy");
  a_low_clamp: assert property (result_valid && lo_seen |-> result == 10'h000)
    else $error("below ground not zero");
  a_high_clamp: assert property (result_valid && hi_seen && !lo_seen |-> result == 10'h3ff)
    else $error("above reference not full scale");
  a_idle_no_window: assert property (!busy |-> !sample_hold)
    else $error("window open while idle");
  a_cal_no_rise: assert property ($rose(calibrating) |-> $past(sys_rst))
    else $error("calibration restarted without reset");
endmodule

bind adc_conversion_timing_ctrl adc_ctrl_checker adc_ctrl_checker_inst (.mclk(mclk), .sys_rst(sys_rst),
  .start_conversion(start_conversion), .basic_clock_divider_select(basic_clock_divider_select),
  .sample_time_select(sample_time_select), .over_ref(over_ref), .under_gnd(under_gnd),
  .sample_hold(sample_hold), .dac_trial(dac_trial), .result(result), .result_valid(result_valid),
  .busy(busy), .calibrating(calibrating));

// >>> analog_source_model.sv
// analog source facing the converter pins
module analog_source_model (
  input wire logic       mclk,        // cpu clock
  input wire logic       sample_hold, // window open
  input wire logic [9:0] dac_trial,   // trial code
  input int              level,       // input in codes, outside 0..1023 is out of range
  output logic           comp_above,  // held input at or above trial
  output logic           over_ref,    // above reference
  output logic           under_gnd    // below ground
);
  timeunit 1ns;
  timeprecision 1ns;
  int held;
  // hold charge follows the pin only while the window is open
  always_ff @(posedge mclk) if (sample_hold) held <= level;
  // flags follow the live pin, compare uses the held charge
  assign comp_above = held >= int'(dac_trial);
  assign over_ref = level > 1023;
  assign under_gnd = level < 0;
endmodule

// >>> adc_conversion_timing_ctrl_tb.sv
// self-checking bench for the conversion timing control
module adc_conversion_timing_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       start_conversion = 1'b0;
  logic [1:0] div_sel = 2'h0;
  logic [1:0] smp_sel = 2'h0;
  logic       comp_above, over_ref, under_gnd, sample_hold, result_valid, busy, calibrating;
  logic [9:0] dac_trial, result;
  int         level = 0;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         seed = 47961;
  int         corner [4] = '{0, 1023, -5, 1030};

  adc_conversion_timing_ctrl adc_conversion_timing_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst),
    .start_conversion(start_conversion), .basic_clock_divider_select(div_sel), .sample_time_select(smp_sel),
    .comp_above(comp_above), .over_ref(over_ref), .under_gnd(under_gnd), .sample_hold(sample_hold),
    .dac_trial(dac_trial), .result(result), .result_valid(result_valid), .busy(busy), .calibrating(calibrating));
  analog_source_model analog_source_model_inst (.mclk(mclk), .sample_hold(sample_hold), .dac_trial(dac_trial),
    .level(level), .comp_above(comp_above), .over_ref(over_ref), .under_gnd(under_gnd));

  initial begin
    forever #25 mclk = ~mclk;
  end
  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one conversion from the current edge; returns at the edge that sees the write pulse
  task automatic convert(input logic [1:0] dc, input logic [1:0] sc, input int lv);
    int d;
    int n;
    int cnt;
    int sh;
    d = dc == 2'h0 ? 4 : dc == 2'h1 ? 2 : dc == 2'h2 ? 16 : 8;
    n = 8 << sc;
    cnt = 0;
    sh = 0;
    div_sel <= dc;
    smp_sel <= sc;
    level <= lv;
    start_conversion <= 1'b1;
    @(posedge mclk);
    start_conversion <= 1'b0;
    while (result_valid !== 1'b1 && cnt < 3000) begin
      @(posedge mclk);
      cnt++;
      sh += int'(sample_hold === 1'b1);
      // a stray start mid-conversion must be ignored
      if (cnt == 5 || cnt == 6) start_conversion <= cnt == 5;
      // pin moves well after the window has closed
      if (cnt == d * n + 4) level <= lv < 512 ? 2000 : -1;
    end
    // outputs are read before each edge lands, hence the extra cycle
    check_val(16'(cnt), 16'(d * (n + 40) + 3));
    // window stands from the start edge to the last sample tick edge
    check_val(16'(sh), 16'(d * n + 1));
    check_val(16'(result), 16'(lv < 0 ? 0 : lv > 1023 ? 1023 : lv));
  endtask

  // calibration with an early conversion, then every code pair back to back
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (100) @(posedge mclk);
    convert(2'h0, 2'h0, 300);
    repeat (13172) @(posedge mclk);
    check_val(16'(calibrating), 16'h0001);
    repeat (60) @(posedge mclk);
    check_val(16'(calibrating), 16'h0000);
    // code 01 exceeds the analog clock limit at this cpu rate, yet its timing and result are checked like every other code
    for (int i = 0; i < 16; i++) begin
      convert(2'(i >> 2), 2'(i), $random(seed) % 700 + 400);
    end
    // range corners at cpu/4, inside the allowed basic clock band
    foreach (corner[k]) begin
      convert(2'h0, 2'(k), corner[k]);
    end
    print_verdict();
  end
endmodule
